// File: uart_register_decode_loopback.sv
// Dual UART channel register decode with internal loopback
// Overview of operation
// - Modem control loop bit enters, clear leaves
// - In loopback transmit shifter feeds receive shifter
// - Loopback: TX high, RTS/DTR off, modem ignored
// - Loopback keeps every other channel function alive
// - Chip/channel select plus three address lines
// - Address 0 normal bank: receive/transmit holding
// - Divisor bank: divisor low, high, alternate function
// - Zero divisor: read revision and identification codes
// - Address 1 normal bank: interrupt enable
// - Address 2: read status, write FIFO control
// - Address 3 line control; 4 modem control
// - Addresses 5,6 read status; writes ignored
// - Address 7, swap bit clear: scratch byte
// - Address 7, swap bit set: level/mode select
// - Key bank address 0: trigger / level count
// - Key bank: feature control, enhanced function
// - Key bank 4-7: two resume, two pause chars
// - Extended bits usable only with enhance bit
module uart_register_decode_loopback #(
  parameter logic [7:0] REV_CODE = 8'h01, // Arbitrary value
  parameter logic [7:0] DEV_ID   = 8'h5A  // Arbitrary value
) (
  input  wire logic                      clk_sys_in,
  input  wire logic                      rst_in,
  input  wire logic                      cs_n_in,
  input  wire logic                      channel_select_in,
  input  wire logic [2:0]                addr_in,
  input  wire logic                      rd_n_in,
  input  wire logic                      wr_n_in,
  input  wire logic [7:0]                data_in,
  output logic      [7:0]                data_out,
  output logic                           data_oe_n_out,
  input  wire logic [1:0]                rx_pin_in,
  input  wire logic [7:0]                modem_n_in,
  input  wire logic [1:0]                tx_shift_in,
  output logic      [1:0]                tx_pin_out,
  output logic      [1:0]                rts_n_out,
  output logic      [1:0]                dtr_n_out,
  output logic      [1:0]                rx_shift_out,
  input  wire logic [15:0]               core_rx_data_in,
  input  wire logic [15:0]               core_line_status_in,
  input  wire logic [15:0]               core_int_status_in,
  input  wire logic [15:0]               core_fifo_level_in,
  output logic                           core_rd_out,
  output logic                           core_rd_chan_out,
  output logic                           core_wr_out,
  output logic                           core_wr_chan_out,
  output uart_decode_pkg::reg_sel_t      core_wr_sel_out,
  output logic      [7:0]                core_wr_data_out
);
  // ************************************************
  // State
  // ************************************************
  typedef struct packed {
    logic [14:0]      bus_s1;
    logic [14:0]      bus_s2;
    logic             rd_n_q;
    logic             wr_n_q;
    logic [1:0]       rx_s1;
    logic [1:0]       rx_s2;
    logic [7:0]       mod_s1;
    logic [7:0]       mod_s2;
    logic [7:0]       mod_prev;
    logic [1:0][3:0]  delta;
    logic [1:0][7:0]  line_control;
    logic [1:0][7:0]  modem_control;
    logic [1:0][7:0]  interrupt_enable;
    logic [1:0][7:0]  enhanced_function;
    logic [1:0][7:0]  feature_control;
    logic [1:0][7:0]  alternate_function;
    logic [1:0][7:0]  dll;
    logic [1:0][7:0]  divisor_high;
    logic [1:0][7:0]  scratch_byte;
    logic [1:0][3:0][7:0] flow;
    logic [7:0]       dout;
    logic             doe_n;
    logic [1:0]       tx;
    logic [1:0]       rts_n;
    logic [1:0]       dtr_n;
    logic [1:0]       rx_shift;
    logic             c_rd;
    logic             c_rd_ch;
    logic             c_wr;
    logic             c_wr_ch;
    uart_decode_pkg::reg_sel_t c_wr_sel;
    logic [7:0]       c_wr_data;
  } state_t;

  state_t q;
  state_t n;

  // ************************************************
  // Helpers
  // ************************************************
  function automatic uart_decode_pkg::reg_sel_t decode(
    input logic [2:0] a,
    input logic [7:0] line_control,
    input logic       swap,
    input logic       div_zero,
    input logic       is_read
  );
    uart_decode_pkg::reg_sel_t s;
    s = uart_decode_pkg::SEL_LCR;
    if (line_control == uart_decode_pkg::ENH_KEY) begin
      unique case (a)
        3'h0: s = uart_decode_pkg::SEL_TRG_FC;
        3'h1: s = uart_decode_pkg::SEL_FEATURE_CONTROL;
        3'h2: s = uart_decode_pkg::SEL_EFR;
        3'h3: s = uart_decode_pkg::SEL_LCR;
        3'h4: s = uart_decode_pkg::SEL_XON1;
        3'h5: s = uart_decode_pkg::SEL_XON2;
        3'h6: s = uart_decode_pkg::SEL_XOFF1;
        3'h7: s = uart_decode_pkg::SEL_XOFF2;
      endcase
    end else begin
      unique case (a)
        3'h0: begin
          if (line_control[uart_decode_pkg::LCR_DIV]) begin
            s = (div_zero && is_read) ? uart_decode_pkg::SEL_REV : uart_decode_pkg::SEL_DLL;
          end else begin
            s = uart_decode_pkg::SEL_HOLD;
          end
        end
        3'h1: begin
          if (line_control[uart_decode_pkg::LCR_DIV]) begin
            s = (div_zero && is_read) ? uart_decode_pkg::SEL_ID : uart_decode_pkg::SEL_DLM;
          end else begin
            s = uart_decode_pkg::SEL_IER;
          end
        end
        3'h2: s = line_control[uart_decode_pkg::LCR_DIV] ? uart_decode_pkg::SEL_AFR
                                              : uart_decode_pkg::SEL_ISR_FCR;
        3'h3: s = uart_decode_pkg::SEL_LCR;
        3'h4: s = uart_decode_pkg::SEL_MCR;
        3'h5: s = uart_decode_pkg::SEL_LSR;
        3'h6: s = uart_decode_pkg::SEL_MSR;
        3'h7: s = swap ? uart_decode_pkg::SEL_FIFO_LEVEL_COUNT_ENHANCED_MODE_SELECT
                       : uart_decode_pkg::SEL_SPR;
      endcase
    end
    return s;
  endfunction

  // Extended bits pass only with the enhance bit on
  function automatic logic [7:0] rd_gate(
    input logic [7:0] v,
    input logic [7:0] mask,
    input logic       enh
  );
    return enh ? v : (v & ~mask);
  endfunction

  function automatic logic [7:0] wr_gate(
    input logic [7:0] v,
    input logic [7:0] old,
    input logic [7:0] mask,
    input logic       enh
  );
    return enh ? v : ((v & ~mask) | (old & mask));
  endfunction

  // Decoded view of the synchronised bus
  logic                      cs_n;
  logic                      ch;
  logic [2:0]                addr;
  logic                      rd_n;
  logic                      wr_n;
  logic [7:0]                din;
  logic                      rd_act;
  logic                      rd_fall;
  logic                      wr_rise;
  logic                      enh;
  logic                      div_zero;
  uart_decode_pkg::reg_sel_t sel_r;
  uart_decode_pkg::reg_sel_t sel_w;

  always_comb begin
    cs_n     = q.bus_s2[14];
    ch       = q.bus_s2[13];
    addr     = q.bus_s2[12:10];
    rd_n     = q.bus_s2[9];
    wr_n     = q.bus_s2[8];
    din      = q.bus_s2[7:0];
    rd_act   = !rd_n && !cs_n;
    rd_fall  = q.rd_n_q && rd_act;
    wr_rise  = !q.wr_n_q && wr_n && !cs_n;
    enh      = q.enhanced_function[ch][uart_decode_pkg::EFR_ENH];
    div_zero = (q.dll[ch] == 8'h00) && (q.divisor_high[ch] == 8'h00);
    sel_r    = decode(addr, q.line_control[ch], q.feature_control[ch][uart_decode_pkg::FEATURE_CONTROL_SWAP], div_zero, 1'b1);
    sel_w    = decode(addr, q.line_control[ch], q.feature_control[ch][uart_decode_pkg::FEATURE_CONTROL_SWAP], div_zero, 1'b0);
  end

  // ************************************************
  // Next state
  // ************************************************
  always_comb begin
    logic [7:0] rdata;
    logic [3:0] chg;
    logic       loop;
    rdata = 8'h00;
    chg   = 4'h0;
    loop  = 1'b0;
    n     = q;
    // Bus, receive and modem pins cross two flops; only the second is read
    n.bus_s1 = {cs_n_in, channel_select_in, addr_in, rd_n_in, wr_n_in, data_in};
    n.bus_s2 = q.bus_s1;
    n.rd_n_q = rd_n;
    n.wr_n_q = wr_n;
    n.rx_s1  = rx_pin_in;
    n.rx_s2  = q.rx_s1;
    n.mod_s1 = modem_n_in;
    n.mod_s2 = q.mod_s1;
    n.mod_prev = q.mod_s2;
    n.c_rd   = 1'b0;
    n.c_wr   = 1'b0;

    for (int c = 0; c < 2; c++) begin
      loop = q.modem_control[c][uart_decode_pkg::MCR_LOOP];
      // Modem changes ignored while looped
      chg = loop ? 4'h0 : (q.mod_s2[c*4 +: 4] ^ q.mod_prev[c*4 +: 4]);
      // A change landing on the clearing read still sticks
      if (rd_fall && ch == c && sel_r == uart_decode_pkg::SEL_MSR) begin
        n.delta[c] = chg;
      end else begin
        n.delta[c] = q.delta[c] | chg;
      end
      n.tx[c]       = loop ? 1'b1 : tx_shift_in[c];
      n.rts_n[c]    = loop ? 1'b1 : !q.modem_control[c][uart_decode_pkg::MCR_RTS];
      n.dtr_n[c]    = loop ? 1'b1 : !q.modem_control[c][uart_decode_pkg::MCR_DTR];
      n.rx_shift[c] = loop ? tx_shift_in[c] : q.rx_s2[c];
    end

    // Read data path
    unique case (sel_r)
      uart_decode_pkg::SEL_HOLD:      rdata = core_rx_data_in[ch*8 +: 8];
      uart_decode_pkg::SEL_DLL:       rdata = q.dll[ch];
      uart_decode_pkg::SEL_DLM:       rdata = q.divisor_high[ch];
      uart_decode_pkg::SEL_AFR:       rdata = q.alternate_function[ch];
      uart_decode_pkg::SEL_REV:       rdata = REV_CODE;
      uart_decode_pkg::SEL_ID:        rdata = DEV_ID;
      uart_decode_pkg::SEL_IER:       rdata = rd_gate(q.interrupt_enable[ch], uart_decode_pkg::IER_EXT, enh);
      uart_decode_pkg::SEL_ISR_FCR:   rdata = rd_gate(core_int_status_in[ch*8 +: 8],
                                                      uart_decode_pkg::ISR_EXT, enh);
      uart_decode_pkg::SEL_LCR:       rdata = q.line_control[ch];
      uart_decode_pkg::SEL_MCR:       rdata = rd_gate(q.modem_control[ch], uart_decode_pkg::MCR_EXT, enh);
      uart_decode_pkg::SEL_LSR:       rdata = core_line_status_in[ch*8 +: 8];
      uart_decode_pkg::SEL_MSR: begin
        rdata[7:4] = q.modem_control[ch][uart_decode_pkg::MCR_LOOP] ? 4'h0 : ~q.mod_s2[ch*4 +: 4];
        rdata[3:0] = q.delta[ch];
      end
      uart_decode_pkg::SEL_SPR:       rdata = q.scratch_byte[ch];
      uart_decode_pkg::SEL_FIFO_LEVEL_COUNT_ENHANCED_MODE_SELECT: rdata = core_fifo_level_in[ch*8 +: 8];
      uart_decode_pkg::SEL_TRG_FC:    rdata = core_fifo_level_in[ch*8 +: 8];
      uart_decode_pkg::SEL_FEATURE_CONTROL:      rdata = q.feature_control[ch];
      uart_decode_pkg::SEL_EFR:       rdata = q.enhanced_function[ch];
      uart_decode_pkg::SEL_XON1:      rdata = q.flow[ch][0];
      uart_decode_pkg::SEL_XON2:      rdata = q.flow[ch][1];
      uart_decode_pkg::SEL_XOFF1:     rdata = q.flow[ch][2];
      uart_decode_pkg::SEL_XOFF2:     rdata = q.flow[ch][3];
    endcase
    n.dout  = rdata;
    n.doe_n = !rd_act;
    if (rd_fall && sel_r == uart_decode_pkg::SEL_HOLD) begin
      n.c_rd    = 1'b1;
      n.c_rd_ch = ch;
    end

    // Write path; status addresses simply fall through
    if (wr_rise) begin
      unique case (sel_w)
        uart_decode_pkg::SEL_DLL:   n.dll[ch] = din;
        uart_decode_pkg::SEL_DLM:   n.divisor_high[ch] = din;
        uart_decode_pkg::SEL_AFR:   n.alternate_function[ch] = din;
        uart_decode_pkg::SEL_IER:   n.interrupt_enable[ch] = wr_gate(din, q.interrupt_enable[ch],
                                                         uart_decode_pkg::IER_EXT, enh);
        uart_decode_pkg::SEL_LCR:   n.line_control[ch] = din;
        uart_decode_pkg::SEL_MCR:   n.modem_control[ch] = wr_gate(din, q.modem_control[ch],
                                                         uart_decode_pkg::MCR_EXT, enh);
        uart_decode_pkg::SEL_SPR:   n.scratch_byte[ch] = din;
        uart_decode_pkg::SEL_FEATURE_CONTROL:  n.feature_control[ch] = din;
        uart_decode_pkg::SEL_EFR:   n.enhanced_function[ch] = din;
        uart_decode_pkg::SEL_XON1:  n.flow[ch][0] = din;
        uart_decode_pkg::SEL_XON2:  n.flow[ch][1] = din;
        uart_decode_pkg::SEL_XOFF1: n.flow[ch][2] = din;
        uart_decode_pkg::SEL_XOFF2: n.flow[ch][3] = din;
        uart_decode_pkg::SEL_HOLD,
        uart_decode_pkg::SEL_ISR_FCR,
        uart_decode_pkg::SEL_FIFO_LEVEL_COUNT_ENHANCED_MODE_SELECT,
        uart_decode_pkg::SEL_TRG_FC: begin
          n.c_wr     = 1'b1;
          n.c_wr_ch  = ch;
          n.c_wr_sel = sel_w;
          n.c_wr_data = (sel_w == uart_decode_pkg::SEL_ISR_FCR)
                        ? rd_gate(din, uart_decode_pkg::FCR_EXT, enh) : din;
        end
        default: ;
      endcase
    end
  end

  // ************************************************
  // Registers
  // ************************************************
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      q          <= '0;
      q.bus_s1   <= 15'h7FFF;
      q.bus_s2   <= 15'h7FFF;
      q.rd_n_q   <= 1'b1;
      q.wr_n_q   <= 1'b1;
      q.doe_n    <= 1'b1;
      q.tx       <= 2'h3;
      q.rts_n    <= 2'h3;
      q.dtr_n    <= 2'h3;
      q.rx_shift <= 2'h3;
      // Idle levels, so no false change or break follows reset
      q.rx_s1    <= 2'h3;
      q.rx_s2    <= 2'h3;
      q.mod_s1   <= 8'hFF;
      q.mod_s2   <= 8'hFF;
      q.mod_prev <= 8'hFF;
      q.line_control      <= {2{uart_decode_pkg::RST_VAL}};
    end else begin
      q <= n;
    end
  end

  assign data_out         = q.dout;
  assign data_oe_n_out    = q.doe_n;
  assign tx_pin_out       = q.tx;
  assign rts_n_out        = q.rts_n;
  assign dtr_n_out        = q.dtr_n;
  assign rx_shift_out     = q.rx_shift;
  assign core_rd_out      = q.c_rd;
  assign core_rd_chan_out = q.c_rd_ch;
  assign core_wr_out      = q.c_wr;
  assign core_wr_chan_out = q.c_wr_ch;
  assign core_wr_sel_out  = q.c_wr_sel;
  assign core_wr_data_out = q.c_wr_data;

  // ************************************************
  // Checks
  // ************************************************
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (rst_in);

  loop_enter_a: assert property (wr_rise && sel_w == uart_decode_pkg::SEL_MCR && din[4]
    |=> q.modem_control[$past(ch)][uart_decode_pkg::MCR_LOOP])
    else $error("loop bit not stored");
  loop_path_a: assert property (q.modem_control[1][uart_decode_pkg::MCR_LOOP]
    |=> rx_shift_out[1] == $past(tx_shift_in[1]))
    else $error("loop path broken");
  loop_pins_a: assert property (q.modem_control[1][uart_decode_pkg::MCR_LOOP]
    |=> tx_pin_out[1] && rts_n_out[1] && dtr_n_out[1])
    else $error("pins not idle in loopback");
  normal_rx_a: assert property (!q.modem_control[0][uart_decode_pkg::MCR_LOOP]
    |=> rx_shift_out[0] == $past(q.rx_s2[0]))
    else $error("receive path wrong");
  read_oe_a: assert property (rd_act |=> !data_oe_n_out)
    else $error("bus not driven on read");
  read_release_a: assert property (!rd_act |=> data_oe_n_out)
    else $error("bus driven without read");
  hold_write_a: assert property (wr_rise && sel_w == uart_decode_pkg::SEL_HOLD
    |=> core_wr_out && core_wr_sel_out == uart_decode_pkg::SEL_HOLD
        && core_wr_data_out == $past(din))
    else $error("transmit write lost");
  id_read_a: assert property (rd_act && sel_r == uart_decode_pkg::SEL_ID
    |=> data_out == DEV_ID)
    else $error("identification wrong");
  status_write_a: assert property (wr_rise && (sel_w == uart_decode_pkg::SEL_LSR
    || sel_w == uart_decode_pkg::SEL_MSR) |=> !core_wr_out && $stable(q.line_control))
    else $error("status write had effect");
  ext_gate_a: assert property (rd_act && !enh && sel_r == uart_decode_pkg::SEL_IER
    |=> data_out[7:4] == 4'h0)
    else $error("gated bits visible");
  enh_decode_a: assert property (q.line_control[ch] == uart_decode_pkg::ENH_KEY && addr == 3'h2
    |-> sel_w == uart_decode_pkg::SEL_EFR)
    else $error("enhanced bank decode wrong");

  loop_cover_c: cover property (wr_rise && sel_w == uart_decode_pkg::SEL_MCR && din[4]);
  enh_cover_c: cover property (wr_rise && sel_w == uart_decode_pkg::SEL_XOFF2);
  id_cover_c: cover property (rd_act && sel_r == uart_decode_pkg::SEL_ID);
endmodule

// File: uart_decode_pkg.sv
// Shared constants and types for the dual-channel register decoder
package uart_decode_pkg;
  // ************************************************
  // Register addresses within a channel
  // ************************************************
  localparam logic [2:0] A_HOLD = 3'h0;
  localparam logic [2:0] A_IER  = 3'h1;
  localparam logic [2:0] A_ISR  = 3'h2;
  localparam logic [2:0] A_LCR  = 3'h3;
  localparam logic [2:0] A_MCR  = 3'h4;
  localparam logic [2:0] A_LSR  = 3'h5;
  localparam logic [2:0] A_MSR  = 3'h6;
  localparam logic [2:0] A_SPR  = 3'h7;
  // ************************************************
  // Field positions, keys and masks
  // ************************************************
  localparam int         LCR_DIV   = 7;
  localparam int         MCR_LOOP  = 4;
  localparam int         MCR_RTS   = 1;
  localparam int         MCR_DTR   = 0;
  localparam int         EFR_ENH   = 4;
  localparam int         FEATURE_CONTROL_SWAP = 6;
  localparam logic [7:0] ENH_KEY   = 8'hBF;
  localparam logic [7:0] RST_VAL   = 8'h00;
  localparam logic [7:0] IER_EXT   = 8'hF0;
  localparam logic [7:0] ISR_EXT   = 8'h30;
  localparam logic [7:0] FCR_EXT   = 8'h30;
  localparam logic [7:0] MCR_EXT   = 8'hE0;
  // ************************************************
  // Decoded register selection
  // ************************************************
  typedef enum logic [4:0] {
    SEL_HOLD, SEL_DLL, SEL_DLM, SEL_AFR, SEL_REV, SEL_ID,
    SEL_IER, SEL_ISR_FCR, SEL_LCR, SEL_MCR, SEL_LSR, SEL_MSR,
    SEL_SPR, SEL_FIFO_LEVEL_COUNT_ENHANCED_MODE_SELECT, SEL_TRG_FC, SEL_FEATURE_CONTROL, SEL_EFR,
    SEL_XON1, SEL_XON2, SEL_XOFF1, SEL_XOFF2
  } reg_sel_t;
endpackage

// File: core_side_model.sv
// Model of the UART core and serial far end facing the decoder
module core_side_model (
  input  wire logic        clk_sys_in,
  input  wire logic [1:0]  tx_bit_in,
  output logic      [1:0]  tx_shift_out,
  output logic      [1:0]  rx_pin_out,
  output logic      [7:0]  modem_n_out,
  output logic      [15:0] rx_data_out,
  output logic      [15:0] line_status_out,
  output logic      [15:0] int_status_out,
  output logic      [15:0] fifo_level_out
);
  timeunit 1ns;
  timeprecision 100ps;
  // ****************************************
  // Core side, same clock as the decoder
  // ****************************************
  initial tx_shift_out = 2'h3;
  always @(posedge clk_sys_in) begin
    tx_shift_out <= tx_bit_in;
  end
  // Receive pins stay at mark so leaving loopback sees no break
  assign rx_pin_out      = 2'h3;
  // Modem inputs idle; they are inactive high
  assign modem_n_out     = 8'hFF;
  assign rx_data_out     = 16'h3CA5;
  assign line_status_out = 16'h6061;
  assign int_status_out  = 16'h01C1;
  assign fifo_level_out  = 16'h1127;
endmodule

// File: tb_uart_register_decode_loopback.sv
// Testbench for the dual-channel register decoder and loopback
module tb_uart_register_decode_loopback;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [7:0] REV = 8'h01; // Arbitrary value
  localparam logic [7:0] DID = 8'h5A; // Arbitrary value
  logic clk_sys_in = 1'b0;
  logic rst_in = 1'b1;
  logic cs_n = 1'b1;
  logic chan = 1'b0;
  logic [2:0] addr = 3'h0;
  logic rd_n = 1'b1;
  logic wr_n = 1'b1;
  logic [7:0] wdata = 8'h00;
  logic [1:0] tx_bit = 2'h1;
  logic [7:0] data_out, wr_dat, q;
  logic data_oe_n, core_rd, rd_chan, core_wr, wr_chan, last_rd_chan;
  logic [1:0] tx_shift, rx_pin, tx_pin, rts_n, dtr_n, rx_shift;
  logic [7:0] modem_n;
  logic [15:0] rx_data, line_status, interrupt_status, fifo_level_count;
  uart_decode_pkg::reg_sel_t wr_sel, last_sel;
  int fails = 0;
  int check_count = 0;
  int wr_cnt = 0;
  always #5 clk_sys_in = ~clk_sys_in;
  core_side_model model (.clk_sys_in(clk_sys_in), .tx_bit_in(tx_bit), .tx_shift_out(tx_shift),
    .rx_pin_out(rx_pin), .modem_n_out(modem_n), .rx_data_out(rx_data),
    .line_status_out(line_status), .int_status_out(interrupt_status), .fifo_level_out(fifo_level_count));
  uart_register_decode_loopback #(.REV_CODE(REV), .DEV_ID(DID)) uut (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .cs_n_in(cs_n), .channel_select_in(chan),
    .addr_in(addr), .rd_n_in(rd_n), .wr_n_in(wr_n), .data_in(wdata), .data_out(data_out),
    .data_oe_n_out(data_oe_n), .rx_pin_in(rx_pin), .modem_n_in(modem_n),
    .tx_shift_in(tx_shift), .tx_pin_out(tx_pin), .rts_n_out(rts_n), .dtr_n_out(dtr_n),
    .rx_shift_out(rx_shift), .core_rx_data_in(rx_data), .core_line_status_in(line_status),
    .core_int_status_in(interrupt_status), .core_fifo_level_in(fifo_level_count), .core_rd_out(core_rd),
    .core_rd_chan_out(rd_chan), .core_wr_out(core_wr), .core_wr_chan_out(wr_chan),
    .core_wr_sel_out(wr_sel), .core_wr_data_out(wr_dat));
  // ****************************************
  // Capture of core pulses
  // ****************************************
  always @(posedge clk_sys_in) begin
    if (core_wr === 1'b1) begin
      wr_cnt++;
      last_sel = wr_sel;
    end
    if (core_rd === 1'b1) last_rd_chan = rd_chan;
  end
  // ****************************************
  // Bus and compare tasks
  // ****************************************
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Write is taken on the rising strobe; hold address and data after it
  task automatic wr(input logic ch, input logic [2:0] a, input logic [7:0] d);
    @(negedge clk_sys_in);
    cs_n = 1'b0;
    chan = ch;
    addr = a;
    wdata = d;
    wr_n = 1'b0;
    repeat (4) @(negedge clk_sys_in);
    wr_n = 1'b1;
    repeat (5) @(negedge clk_sys_in);
    cs_n = 1'b1;
    repeat (3) @(negedge clk_sys_in);
  endtask
  task automatic rd(input logic ch, input logic [2:0] a, input logic [7:0] e);
    int n;
    @(negedge clk_sys_in);
    cs_n = 1'b0;
    chan = ch;
    addr = a;
    rd_n = 1'b0;
    n = 0;
    while (data_oe_n !== 1'b0 && n < 10) begin
      @(negedge clk_sys_in);
      n++;
    end
    if (n >= 10) begin
      fails++;
      final_report();
    end
    @(negedge clk_sys_in);
    chk(data_out, e);
    rd_n = 1'b1;
    repeat (5) @(negedge clk_sys_in);
    cs_n = 1'b1;
    repeat (3) @(negedge clk_sys_in);
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    int c;
    repeat (12) @(negedge clk_sys_in);
    rst_in = 1'b0;
    chk({7'h0, data_oe_n}, 8'h01);
    repeat (3) @(negedge clk_sys_in);
    // Divisor bank with zero divisor shows the codes
    wr(1'b0, 3'h3, 8'h80);
    rd(1'b0, 3'h0, REV);
    rd(1'b0, 3'h1, DID);
    wr(1'b0, 3'h0, 8'h12);
    rd(1'b0, 3'h0, 8'h12);
    wr(1'b0, 3'h2, 8'h05);
    rd(1'b0, 3'h2, 8'h05);
    // Key bank: feature, enhanced and flow characters
    wr(1'b0, 3'h3, 8'hBF);
    rd(1'b0, 3'h3, 8'hBF);
    wr(1'b0, 3'h1, 8'h40);
    wr(1'b0, 3'h2, 8'h10);
    rd(1'b0, 3'h1, 8'h40);
    rd(1'b0, 3'h2, 8'h10);
    for (c = 4; c < 8; c++) wr(1'b0, c[2:0], 8'h11 * c[7:0]);
    for (c = 4; c < 8; c++) rd(1'b0, c[2:0], 8'h11 * c[7:0]);
    rd(1'b0, 3'h0, 8'h27);
    // Normal bank, enhance bit set on channel 0
    wr(1'b0, 3'h3, 8'h03);
    wr(1'b0, 3'h1, 8'hF5);
    rd(1'b0, 3'h1, 8'hF5);
    rd(1'b0, 3'h7, 8'h27);
    wr(1'b0, 3'h2, 8'h31);
    chk({3'h0, last_sel}, {3'h0, uart_decode_pkg::SEL_ISR_FCR});
    chk(wr_dat, 8'h31);
    // Channel 1 has its own set, enhance bit clear
    wr(1'b1, 3'h1, 8'hF5);
    rd(1'b1, 3'h1, 8'h05);
    wr(1'b1, 3'h7, 8'h5A);
    rd(1'b1, 3'h7, 8'h5A);
    rd(1'b1, 3'h0, 8'h3C);
    chk({7'h0, last_rd_chan}, 8'h01);
    wr(1'b1, 3'h0, 8'h77);
    chk({3'h0, last_sel}, {3'h0, uart_decode_pkg::SEL_HOLD});
    chk(wr_dat, 8'h77);
    c = wr_cnt;
    wr(1'b1, 3'h5, 8'hFF);
    wr(1'b1, 3'h6, 8'hFF);
    chk(8'(wr_cnt - c), 8'h00);
    rd(1'b1, 3'h5, 8'h60);
    rd(1'b1, 3'h6, 8'h00);
    rd(1'b1, 3'h2, 8'h01);
    // Loopback on channel 1 only
    tx_bit = 2'h1;
    wr(1'b1, 3'h4, 8'hE3);
    rd(1'b1, 3'h4, 8'h03);
    chk({6'h0, rts_n}, 8'h01);
    chk({6'h0, tx_pin}, 8'h01);
    chk({6'h0, rx_shift}, 8'h03);
    wr(1'b1, 3'h4, 8'h13);
    chk({6'h0, rts_n}, 8'h03);
    chk({6'h0, dtr_n}, 8'h03);
    chk({6'h0, tx_pin}, 8'h03);
    chk({6'h0, rx_shift}, 8'h01);
    rd(1'b1, 3'h5, 8'h60);
    wr(1'b1, 3'h4, 8'h03);
    chk({6'h0, tx_pin}, 8'h01);
    chk({6'h0, rx_shift}, 8'h03);
    final_report();
  end
endmodule
